//--- logic/cput_regs.vh
`ifndef CPUT_REGS_VH
`define CPUT_REGS_VH

// =============================================
// Memory bus placement (16-bit word addresses)
`define CPUT_AW          22
`define CPUT_BASE_HI     16'h0030
`define CPUT_SPAN_LSB    6
`define CPUT_NUM_TMR     3
`define CPUT_WORDS_PER   8
`define CPUT_USED_WORDS  24

// =============================================
// Word offsets inside one timer slot
`define CPUT_OFS_CNT_LO  3'h0
`define CPUT_OFS_CNT_HI  3'h1
`define CPUT_OFS_PRD_LO  3'h2
`define CPUT_OFS_PRD_HI  3'h3
`define CPUT_OFS_CTRL    3'h4
`define CPUT_OFS_SPARE   3'h5
`define CPUT_OFS_PSC     3'h6
`define CPUT_OFS_PSC_CNT 3'h7

// =============================================
// Control word fields
`define CPUT_CTRL_STOP   0
`define CPUT_CTRL_RELOAD 1
`define CPUT_CTRL_FLAG   15

// =============================================
// Reset values and unit step constants
`define CPUT_PRD_RST     32'hFFFFFFFF
`define CPUT_PSC_RST     16'h0000
`define CPUT_ONE16       16'h0001
`define CPUT_ONE32       32'h00000001

`endif

//--- logic/cput_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "cput_regs.vh"

// One count-down timer: prescaler, 32-bit counter, auto reload
module cput_chan (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire        stop,
   input  wire        reload,
   input  wire [31:0] period,
   input  wire [15:0] psc_div,
   output reg  [31:0] cnt_q,
   output reg  [15:0] psc_q,
   output reg         zero_q
);

   wire        tick;
   wire [15:0] psc_load;

   // Divide value 0 behaves as 1
   assign psc_load = (psc_div == 16'h0000) ? 16'h0000 : (psc_div - `CPUT_ONE16);
   assign tick     = !stop && (psc_q == 16'h0000);

   // =============================================
   // Prescaler and main counter
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= `CPUT_PRD_RST;
         psc_q  <= `CPUT_PSC_RST;
         zero_q <= 1'b0;
      end else begin
         zero_q <= 1'b0;
         if (reload) begin
            cnt_q <= period;
            psc_q <= psc_load;
         end else if (!stop) begin
            if (tick) begin
               psc_q <= psc_load;
               if (cnt_q == 32'h00000000) begin
                  cnt_q  <= period;
                  zero_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - `CPUT_ONE32;
               end
            end else begin
               psc_q <= psc_q - `CPUT_ONE16;
            end
         end
      end
   end

endmodule // cput_chan

`default_nettype wire

//--- logic/cput_top.v
// Behaviour
// - three identical timers, 32-bit period each
// - 16-bit prescaler divides clock per timer
// - 32-bit down-counter raises request at zero
// - counter steps once per prescaler period
// - zero reloads counter from period automatically
// - timer 2 drives CPU line fourteen
// - timer 1 drives CPU line thirteen
// - timer 0 goes to interrupt expander
// - 64 words at base, no unlock
// - 16-bit and 32-bit accesses both accepted
// - reached directly on CPU memory bus
`timescale 1ns/1ps
`default_nettype none
`include "cput_regs.vh"

module cput_top (
   input  wire                 sys_clk,
   input  wire                 rst_b,
   input  wire [`CPUT_AW-1:0]  mem_addr,
   input  wire                 mem_wr,
   input  wire                 mem_rd,
   input  wire                 mem_wide,
   input  wire [31:0]          mem_wdata,
   output reg  [31:0]          mem_rdata_q,
   output reg                  mem_rvalid_q,
   output reg                  interrupt_expander_req_q,
   output reg                  cpu_irq_line_thirteen_q,
   output reg                  cpu_irq_line_fourteen_q
);

   // =============================================
   // Address decode
   wire       hit;
   wire [5:0] wa_lo;
   wire [5:0] wa_hi;

   // Frame lives on the CPU memory bus; no unlock input exists
   assign hit   = (mem_addr[`CPUT_AW-1:`CPUT_SPAN_LSB] == `CPUT_BASE_HI);
   assign wa_lo = mem_addr[`CPUT_SPAN_LSB-1:0];
   assign wa_hi = mem_addr[`CPUT_SPAN_LSB-1:0] + 6'h01;

   wire [15:0] rd_word [0:63];
   wire [2:0]  zero;

   genvar g;
   generate
      for (g = 0; g < `CPUT_NUM_TMR; g = g + 1) begin : g_tmr
         // Slot base cut to the 6-bit word index on purpose
         localparam integer SB_I = g * `CPUT_WORDS_PER;
         localparam [5:0]   SB   = SB_I[5:0];

         reg  [31:0] prd_q;
         reg  [15:0] div_q;
         reg         stop_q;
         reg         reload_q;
         reg         flag_q;
         wire [31:0] cnt;
         wire [15:0] psc;
         reg  [15:0] wdat [0:7];
         reg  [7:0]  wen;
         integer     k;

         // Per-word write strobes, low half at addr, high at addr+1
         always @* begin
            for (k = 0; k < 8; k = k + 1) begin
               wen[k]  = 1'b0;
               wdat[k] = mem_wdata[15:0];
               if (mem_wr && hit && wa_lo == SB + k[5:0]) begin
                  wen[k] = 1'b1;
               end
               if (mem_wr && hit && mem_wide && wa_hi == SB + k[5:0]) begin
                  wen[k]  = 1'b1;
                  wdat[k] = mem_wdata[31:16];
               end
            end
         end

         // Software-written settings and sticky zero flag
         always @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               prd_q    <= `CPUT_PRD_RST;
               div_q    <= `CPUT_PSC_RST;
               stop_q   <= 1'b0;
               reload_q <= 1'b0;
               flag_q   <= 1'b0;
            end else begin
               reload_q <= 1'b0;
               if (wen[`CPUT_OFS_PRD_LO]) begin
                  prd_q[15:0] <= wdat[`CPUT_OFS_PRD_LO];
               end
               if (wen[`CPUT_OFS_PRD_HI]) begin
                  prd_q[31:16] <= wdat[`CPUT_OFS_PRD_HI];
               end
               if (wen[`CPUT_OFS_PSC]) begin
                  div_q <= wdat[`CPUT_OFS_PSC];
               end
               if (wen[`CPUT_OFS_CTRL]) begin
                  stop_q   <= wdat[`CPUT_OFS_CTRL][`CPUT_CTRL_STOP];
                  reload_q <= wdat[`CPUT_OFS_CTRL][`CPUT_CTRL_RELOAD];
               end
               // Event wins over write-one-to-clear
               if (zero[g]) begin
                  flag_q <= 1'b1;
               end else if (wen[`CPUT_OFS_CTRL] && wdat[`CPUT_OFS_CTRL][`CPUT_CTRL_FLAG]) begin
                  flag_q <= 1'b0;
               end
            end
         end

         cput_chan u_chan (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .stop    (stop_q),
            .reload  (reload_q),
            .period  (prd_q),
            .psc_div (div_q),
            .cnt_q   (cnt),
            .psc_q   (psc),
            .zero_q  (zero[g])
         );

         // Read view of this slot
         assign rd_word[SB + {3'h0, `CPUT_OFS_CNT_LO}]  = cnt[15:0];
         assign rd_word[SB + {3'h0, `CPUT_OFS_CNT_HI}]  = cnt[31:16];
         assign rd_word[SB + {3'h0, `CPUT_OFS_PRD_LO}]  = prd_q[15:0];
         assign rd_word[SB + {3'h0, `CPUT_OFS_PRD_HI}]  = prd_q[31:16];
         assign rd_word[SB + {3'h0, `CPUT_OFS_CTRL}]    = {flag_q, 14'h0000, stop_q};
         assign rd_word[SB + {3'h0, `CPUT_OFS_SPARE}]   = 16'h0000;
         assign rd_word[SB + {3'h0, `CPUT_OFS_PSC}]     = div_q;
         assign rd_word[SB + {3'h0, `CPUT_OFS_PSC_CNT}] = psc;
      end
      // Unused words of the 64-word frame read as zero
      for (g = `CPUT_USED_WORDS; g < 64; g = g + 1) begin : g_pad
         assign rd_word[g] = 16'h0000;
      end
   endgenerate

   // =============================================
   // Read data, one cycle after the strobe
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_rdata_q  <= 32'h00000000;
         mem_rvalid_q <= 1'b0;
      end else begin
         mem_rvalid_q <= mem_rd;
         if (mem_rd && hit) begin
            mem_rdata_q <= {mem_wide ? rd_word[wa_hi] : 16'h0000, rd_word[wa_lo]};
         end else if (mem_rd) begin
            mem_rdata_q <= 32'h00000000;
         end
      end
   end

   // =============================================
   // Interrupt routing, one pulse per zero event
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_expander_req_q <= 1'b0;
         cpu_irq_line_thirteen_q  <= 1'b0;
         cpu_irq_line_fourteen_q  <= 1'b0;
      end else begin
         interrupt_expander_req_q <= zero[0];
         cpu_irq_line_thirteen_q  <= zero[1];
         cpu_irq_line_fourteen_q  <= zero[2];
      end
   end

endmodule // cput_top

`default_nettype wire

//--- bench/cput_props.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus and request checks
module cput_props (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [21:0] mem_addr,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic        mem_wide,
   input wire logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata_q,
   input wire logic        mem_rvalid_q,
   input wire logic        interrupt_expander_req_q,
   input wire logic        cpu_irq_line_thirteen_q,
   input wire logic        cpu_irq_line_fourteen_q
);
   logic wr_seen_q;
   wire  frame = mem_addr[21:6] == 16'h0030;
   wire  irq = interrupt_expander_req_q | cpu_irq_line_thirteen_q | cpu_irq_line_fourteen_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Any write since reset
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) wr_seen_q <= 1'h0;
      else if (mem_wr) wr_seen_q <= 1'h1;
   end
   a_read_answered: assert property (mem_rd |=> mem_rvalid_q) else $error("no answer");
   a_no_stray: assert property (!mem_rd |=> !mem_rvalid_q) else $error("stray valid");
   a_outside_zero: assert property (mem_rd && !frame |=> mem_rdata_q == 32'h00000000)
      else $error("outside read");
   a_spare_zero: assert property (mem_rd && frame && mem_addr[5:3] > 3'h2 &&
      mem_addr[5:0] != 6'h3F |=> mem_rdata_q == 32'h00000000) else $error("spare read");
   a_narrow_upper: assert property (mem_rd && !mem_wide |=> mem_rdata_q[31:16] == 16'h0000)
      else $error("upper half");
   a_rdata_holds: assert property (!mem_rd |=> $stable(mem_rdata_q))
      else $error("rdata moved");
   a_quiet_unwritten: assert property (!wr_seen_q |-> !irq) else $error("early request");
   a_period_kept: assert property (mem_wr && !mem_wide && mem_addr == 22'h000C02 ##1
      mem_rd && !mem_wide && mem_addr == 22'h000C02 |=>
      mem_rdata_q[15:0] == $past(mem_wdata[15:0], 2)) else $error("period lost");
endmodule // cput_props
bind cput_top cput_props u_props (.sys_clk, .rst_b, .mem_addr, .mem_wr, .mem_rd, .mem_wide,
   .mem_wdata, .mem_rdata_q, .mem_rvalid_q, .interrupt_expander_req_q,
   .cpu_irq_line_thirteen_q, .cpu_irq_line_fourteen_q);
`default_nettype wire

//--- bench/cput_irq_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Interrupt receiver: tallies request pulses per line
module cput_irq_sink (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  irq,
   output var  logic [23:0] cnt
);
   // One count per request cycle
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) cnt <= 24'h000000;
      else for (int i = 0; i < 3; i++) cnt[8*i+:8] <= cnt[8*i+:8] + {7'h00, irq[i]};
   end
endmodule // cput_irq_sink
`default_nettype wire

//--- bench/cput_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Timer block bench
module cput_tb_top;
   typedef struct {logic [1:0] op; logic [11:0] a; logic [31:0] d;} cput_row_t;
   logic        sys_clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [21:0] mem_addr = 22'h000000;
   logic        mem_wr = 1'h0;
   logic        mem_rd = 1'h0;
   logic        mem_wide = 1'h0;
   logic [31:0] mem_wdata = 32'h00000000;
   logic [31:0] mem_rdata_q;
   logic        mem_rvalid_q;
   wire  [2:0]  irq;
   logic [23:0] cnt;
   logic [23:0] snap;
   int          miscompares = 0;
   int          samples_checked = 0;
   // Op: 0/1 read narrow/wide, 2/3 write narrow/wide
   cput_row_t   rows [10] = '{'{2'h1, 12'hC02, 32'hFFFFFFFF}, '{2'h0, 12'hC06, 32'h00000000},
      '{2'h0, 12'hC03, 32'h0000FFFF}, '{2'h2, 12'hC02, 32'h00001234},
      '{2'h0, 12'hC02, 32'h00001234}, '{2'h3, 12'hC12, 32'hAABBCCDD},
      '{2'h1, 12'hC12, 32'hAABBCCDD}, '{2'h0, 12'hC13, 32'h0000AABB},
      '{2'h1, 12'hC18, 32'h00000000}, '{2'h0, 12'hD00, 32'h00000000}};
   // Clock and units
   always #2 sys_clk = ~sys_clk;
   cput_top dut (.sys_clk, .rst_b, .mem_addr, .mem_wr, .mem_rd, .mem_wide, .mem_wdata,
      .mem_rdata_q, .mem_rvalid_q, .interrupt_expander_req_q(irq[0]),
      .cpu_irq_line_thirteen_q(irq[1]), .cpu_irq_line_fourteen_q(irq[2]));
   cput_irq_sink u_sink (.sys_clk, .rst_b, .irq, .cnt);
   task automatic tally_and_finish;
      $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus request; reads compare the answer
   task automatic access(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d);
      int n;
      mem_addr = {10'h000, a};
      mem_wide = op[0];
      mem_wdata = d;
      mem_wr = op[1];
      mem_rd = !op[1];
      @(posedge sys_clk) #1;
      for (n = 0; n < 4 && !op[1] && mem_rvalid_q !== 1'h1; n++) @(posedge sys_clk) #1;
      if (n == 4) begin
         miscompares++;
         tally_and_finish;
      end
      if (!op[1]) check(32'(n), 32'h00000000);
      if (!op[1]) check(mem_rdata_q, d);
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      #1 rst_b = 1'h1;
      foreach (rows[i]) access(rows[i].op, rows[i].a, rows[i].d);
      mem_rd = 1'h0;
      $display("Register test done");
      for (int t = 0; t < 3; t++) begin
         access(2'h3, 12'hC02 + 12'(8 * t), 32'(t));
         access(2'h2, 12'hC06 + 12'(8 * t), 32'h00000002);
         access(2'h2, 12'hC04 + 12'(8 * t), 32'h00000002);
      end
      mem_wr = 1'h0;
      repeat (10) @(posedge sys_clk);
      #1 snap = cnt;
      repeat (60) @(posedge sys_clk);
      #1 for (int t = 0; t < 3; t++) begin
         check(32'(8'(cnt[8*t+:8] - snap[8*t+:8])), 32'(30 / (t + 1)));
      end
      // Timer 1 has fired: sticky flag set, still running
      access(2'h0, 12'hC0C, 32'h00008000);
      $display("Request rate test done");
      access(2'h2, 12'hC04, 32'h00000001);
      mem_wr = 1'h0;
      repeat (10) @(posedge sys_clk);
      #1 snap = cnt;
      repeat (20) @(posedge sys_clk);
      #1 check({24'h000000, 8'(cnt[7:0] - snap[7:0])}, 32'h00000000);
      // Period 0 keeps the stopped count at zero
      access(2'h1, 12'hC00, 32'h00000000);
      mem_rd = 1'h0;
      $display("Stop test done");
      rst_b = 1'h0;
      #1 check({29'h00000000, irq}, 32'h00000000);
      repeat (2) @(posedge sys_clk);
      #1 rst_b = 1'h1;
      access(2'h1, 12'hC12, 32'hFFFFFFFF);
      mem_rd = 1'h0;
      $display("Reset test done");
      tally_and_finish;
   end
endmodule // cput_tb_top
`default_nettype wire
